//--- common/acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// Shared global address for synchronised conversion start
`define ACS_GLOBAL_ADDR 7'h77
// Result length and bit bookkeeping
`define ACS_RD_LIMIT 5'h18
`define ACS_IDX_LAST 5'h17
`define ACS_BIT_ACK 4'h8
`define ACS_BIT_DONE 4'h9
// Data bytes accepted after an own or a global write address
`define ACS_OWN_WR_BYTES 2'h2
`define ACS_GLB_WR_BYTES 2'h1
// Data bytes of a result read
`define ACS_RD_BYTES 2'h3
// Channel and configuration after reset
`define ACS_CHAN_RESET 8'h00
`define ACS_CFG_RESET 8'h00
// Master clock and serial clock timing
`define ACS_CLK_PERIOD_NS 20
`define ACS_SCL_PERIOD_NS 10000
`define ACS_SCL_QTR_CYCLES ((`ACS_SCL_PERIOD_NS + 4 * `ACS_CLK_PERIOD_NS - 1) / (4 * `ACS_CLK_PERIOD_NS))

`endif

//--- common/acs_pkg.sv
package acs_pkg;

    // Device transfer phase
    typedef enum logic [2:0] {
        ACS_PH_IDLE,
        ACS_PH_ADDR,
        ACS_PH_WRITE,
        ACS_PH_READ,
        ACS_PH_IGNORE
    } acs_phase_t;

    // Master sequencer state
    typedef enum logic [1:0] {
        ACS_M_IDLE,
        ACS_M_START,
        ACS_M_BYTE,
        ACS_M_STOP
    } acs_mstate_t;

    // Complete device state
    typedef struct packed {
        logic sclMeta;
        logic sclSamp;
        logic sclPrev;
        logic sdaMeta;
        logic sdaSamp;
        logic sdaPrev;
        logic [6:0] addrMeta;
        logic [6:0] addrSamp;
        acs_phase_t phase;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic isGlobal;
        logic [1:0] wrCount;
        logic armed;
        logic [4:0] rdIdx;
        logic sdaLow;
        logic ready;
        logic busy;
        logic [23:0] result;
        logic [7:0] pendChan;
        logic [7:0] pendCfg;
        logic pendChanValid;
        logic pendCfgValid;
        logic [7:0] chan;
        logic [7:0] cfg;
        logic startPulse;
    } acs_dev_t;

    // Complete master state
    typedef struct packed {
        acs_mstate_t state;
        logic [15:0] qCnt;
        logic [1:0] quarter;
        logic [3:0] bitIdx;
        logic [1:0] byteIdx;
        logic [1:0] nBytes;
        logic isRead;
        logic nak;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [15:0] wrData;
        logic [23:0] rdData;
        logic addrAck;
        logic sclLow;
        logic sdaLow;
        logic sdaMeta;
        logic sdaSamp;
        logic rspValid;
    } acs_mst_t;

endpackage : acs_pkg

//--- common/acs_link_if.sv
`timescale 1ns/1ns
// Two-wire link; both lines are open drain with pull-ups
interface acs_link_if;
    logic sclO;
    logic sclOeN;
    logic mSdaO;
    logic mSdaOeN;
    logic dSdaO;
    logic dSdaOeN;
    logic scl;
    logic sda;

    // Wired-AND of the drivers, released lines read high
    assign scl = sclOeN ? 1'b1 : sclO;
    assign sda = (mSdaOeN ? 1'b1 : mSdaO) & (dSdaOeN ? 1'b1 : dSdaO);

    modport master (
        output sclO,
        output sclOeN,
        output mSdaO,
        output mSdaOeN,
        input scl,
        input sda
    );

    modport device (
        output dSdaO,
        output dSdaOeN,
        input scl,
        input sda
    );
endinterface : acs_link_if

//--- core/acs_master.sv
`timescale 1ns/1ns
`include "acs_defs.svh"
// Bus master end: serial clock made from mclk by a quarter-period divider
module acs_master
    import acs_pkg::*;
#(
    parameter int unsigned QTR_CYCLES = `ACS_SCL_QTR_CYCLES
)
(
    input wire logic mclk,
    input wire logic rst,
    acs_link_if.master link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [6:0] cmdAddr,
    input wire logic cmdRead,
    input wire logic [1:0] cmdWrLen,
    input wire logic [15:0] cmdWrData,
    input wire logic allConvDone,
    output logic rspValid,
    output logic rspAck,
    output logic [23:0] rspData
);

    acs_mst_t s;
    acs_mst_t next_s;

    logic isGlobalCmd;
    logic globalRead;

    // Global calls wait for every converter to finish
    assign isGlobalCmd = (cmdAddr == `ACS_GLOBAL_ADDR);
    assign globalRead = isGlobalCmd && cmdRead;
    assign cmdReady = (s.state == ACS_M_IDLE) && !s.rspValid
                      && (!isGlobalCmd || allConvDone);

    // Sequencer: each bit takes four quarters of the serial clock
    always_comb
    begin
        logic tick;
        logic txMode;
        tick = 1'b0;
        txMode = 1'b0;
        next_s = s;
        next_s.rspValid = 1'b0;
        next_s.sdaMeta = link.sda;
        next_s.sdaSamp = s.sdaMeta;
        if (s.state != ACS_M_IDLE)
        begin
            tick = (s.qCnt == 16'(QTR_CYCLES - 1));
            next_s.qCnt = tick ? 16'h0000 : s.qCnt + 16'h0001;
        end
        txMode = (s.byteIdx == 2'h0) || !s.isRead;
        case (s.state)
            ACS_M_IDLE:
            begin
                if (cmdValid && cmdReady && globalRead)
                begin
                    // A global read is never put on the bus
                    next_s.addrAck = 1'b0;
                    next_s.rdData = 24'h000000;
                    next_s.rspValid = 1'b1;
                end
                else if (cmdValid && cmdReady)
                begin
                    next_s.state = ACS_M_START;
                    next_s.quarter = 2'h0;
                    next_s.qCnt = 16'h0000;
                    next_s.isRead = cmdRead;
                    next_s.nak = 1'b0;
                    next_s.nBytes = cmdRead ? `ACS_RD_BYTES : cmdWrLen;
                    next_s.wrData = cmdWrData;
                    next_s.tx = {cmdAddr, cmdRead};
                    next_s.rdData = 24'h000000;
                end
            end
            ACS_M_START:
            begin
                if (tick)
                begin
                    next_s.quarter = s.quarter + 2'h1;
                    case (s.quarter)
                        2'h0:
                        begin
                            next_s.sclLow = 1'b0;
                            next_s.sdaLow = 1'b0;
                        end
                        2'h1: next_s.sdaLow = 1'b1;
                        2'h2: next_s.sclLow = 1'b1;
                        default:
                        begin
                            next_s.state = ACS_M_BYTE;
                            next_s.bitIdx = 4'h0;
                            next_s.byteIdx = 2'h0;
                        end
                    endcase
                end
            end
            ACS_M_BYTE:
            begin
                if (tick)
                begin
                    next_s.quarter = s.quarter + 2'h1;
                    case (s.quarter)
                        2'h0:
                        begin
                            // Set the data line while the clock is low
                            if (s.bitIdx != `ACS_BIT_ACK)
                                next_s.sdaLow = txMode && !s.tx[7];
                            else if (txMode)
                                next_s.sdaLow = 1'b0;
                            else
                                next_s.sdaLow = (s.byteIdx != s.nBytes);
                        end
                        2'h1: next_s.sclLow = 1'b0;
                        2'h2:
                        begin
                            if (s.bitIdx != `ACS_BIT_ACK)
                            begin
                                next_s.rx = {s.rx[6:0], s.sdaSamp};
                                next_s.tx = {s.tx[6:0], 1'b0};
                            end
                            else if (txMode)
                            begin
                                next_s.nak = s.sdaSamp;
                                if (s.byteIdx == 2'h0)
                                    next_s.addrAck = !s.sdaSamp;
                            end
                        end
                        default:
                        begin
                            next_s.sclLow = 1'b1;
                            if (s.bitIdx != `ACS_BIT_ACK)
                                next_s.bitIdx = s.bitIdx + 4'h1;
                            else
                            begin
                                if (!txMode)
                                    next_s.rdData = {s.rdData[15:0], s.rx};
                                next_s.bitIdx = 4'h0;
                                // Optional data bytes, then Stop
                                if (s.nak || s.byteIdx == s.nBytes)
                                    next_s.state = ACS_M_STOP;
                                else
                                begin
                                    next_s.byteIdx = s.byteIdx + 2'h1;
                                    next_s.tx = (s.byteIdx == 2'h0)
                                        ? s.wrData[15:8] : s.wrData[7:0];
                                end
                            end
                        end
                    endcase
                end
            end
            default:
            begin
                if (tick)
                begin
                    next_s.quarter = s.quarter + 2'h1;
                    case (s.quarter)
                        2'h0: next_s.sdaLow = 1'b1;
                        2'h1: next_s.sclLow = 1'b0;
                        2'h2: next_s.sdaLow = 1'b0;
                        default:
                        begin
                            next_s.state = ACS_M_IDLE;
                            next_s.rspValid = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign link.sclO = 1'b0;
    assign link.mSdaO = 1'b0;
    assign link.sclOeN = !s.sclLow;
    assign link.mSdaOeN = !s.sdaLow;
    assign rspValid = s.rspValid;
    assign rspAck = s.addrAck;
    assign rspData = s.rdData;

endmodule : acs_master

//--- core/acs_device.sv
`timescale 1ns/1ns
`include "acs_defs.svh"
// Functional notes
// - Acked write then Stop restarts conversion
// - Written channel/config used by next conversion
// - Master waits for all conversions before global
// - Global write address is acknowledged too
// - Global byte then Stop starts all together
// - Bare global Stop keeps channel and configuration
// - Global read request gets not-acknowledge
// - Busy converter not-acknowledges its address
// - Read ends at Stop or 24 bits
// - Finished conversion sleeps until read acknowledged or an acked write ends at Stop
module acs_device
    import acs_pkg::*;
(
    input wire logic linkClk,
    input wire logic rst,
    acs_link_if.device link,
    input wire logic [6:0] ownAddr,
    input wire logic convFinish,
    input wire logic [23:0] convResult,
    output logic convStart,
    output logic convReady,
    output logic [7:0] chanSel,
    output logic [7:0] convCfg
);

    acs_dev_t s;
    acs_dev_t next_s;

    // Link decoding, acknowledge decisions and conversion control
    always_comb
    begin
        logic sclRise;
        logic sclFall;
        logic startCond;
        logic stopCond;
        logic isOwn;
        logic isGlb;
        logic ack;
        logic startNow;
        logic [1:0] wrLimit;
        sclRise = 1'b0;
        sclFall = 1'b0;
        startCond = 1'b0;
        stopCond = 1'b0;
        isOwn = 1'b0;
        isGlb = 1'b0;
        ack = 1'b0;
        startNow = 1'b0;
        wrLimit = 2'h0;
        next_s = s;
        next_s.startPulse = 1'b0;
        // Two-stage synchronisers, then a delayed copy for edges
        next_s.sclMeta = link.scl;
        next_s.sclSamp = s.sclMeta;
        next_s.sclPrev = s.sclSamp;
        next_s.sdaMeta = link.sda;
        next_s.sdaSamp = s.sdaMeta;
        next_s.sdaPrev = s.sdaSamp;
        next_s.addrMeta = ownAddr;
        next_s.addrSamp = s.addrMeta;
        sclRise = s.sclSamp && !s.sclPrev;
        sclFall = !s.sclSamp && s.sclPrev;
        startCond = s.sclSamp && s.sclPrev && s.sdaPrev && !s.sdaSamp;
        stopCond = s.sclSamp && s.sclPrev && !s.sdaPrev && s.sdaSamp;

        // End of conversion: result kept, device sleeps ready
        if (convFinish && s.busy)
        begin
            next_s.busy = 1'b0;
            next_s.ready = 1'b1;
            next_s.result = convResult;
        end

        if (startCond)
        begin
            next_s.phase = ACS_PH_ADDR;
            next_s.bitCnt = 4'h0;
            next_s.sdaLow = 1'b0;
        end
        else if (stopCond)
        begin
            next_s.phase = ACS_PH_IDLE;
            next_s.sdaLow = 1'b0;
            // Stop after an acked write or during a read
            startNow = s.armed;
        end
        else if (sclRise && s.phase != ACS_PH_IDLE
                 && s.phase != ACS_PH_IGNORE)
        begin
            if (s.bitCnt != `ACS_BIT_DONE)
                next_s.bitCnt = s.bitCnt + 4'h1;
            if (s.bitCnt < `ACS_BIT_ACK)
                next_s.shift = {s.shift[6:0], s.sdaSamp};
            if (s.phase == ACS_PH_READ)
            begin
                if (s.bitCnt < `ACS_BIT_ACK && s.rdIdx < `ACS_RD_LIMIT)
                begin
                    next_s.rdIdx = s.rdIdx + 5'h1;
                    // Last result bit out starts the conversion
                    if (s.rdIdx == `ACS_IDX_LAST)
                        startNow = s.armed;
                end
                else if (s.bitCnt == `ACS_BIT_ACK && s.rdIdx != 5'h00
                         && s.sdaSamp)
                    next_s.phase = ACS_PH_IGNORE;
            end
        end
        else if (sclFall && s.phase != ACS_PH_IDLE)
        begin
            if (s.bitCnt == `ACS_BIT_ACK)
            begin
                case (s.phase)
                    ACS_PH_ADDR:
                    begin
                        isOwn = (s.shift[7:1] == s.addrSamp);
                        isGlb = (s.shift[7:1] == `ACS_GLOBAL_ADDR);
                        // Reads to the global address refused
                        if (isGlb)
                            ack = s.ready && !s.shift[0];
                        else
                            ack = s.ready && isOwn;
                        next_s.sdaLow = ack;
                        next_s.isGlobal = isGlb;
                        if (!ack)
                            next_s.phase = ACS_PH_IGNORE;
                        else if (s.shift[0])
                        begin
                            // Read acknowledged: leave sleep
                            next_s.phase = ACS_PH_READ;
                            next_s.ready = 1'b0;
                            next_s.rdIdx = 5'h00;
                            next_s.armed = 1'b1;
                        end
                        else
                        begin
                            next_s.phase = ACS_PH_WRITE;
                            next_s.wrCount = 2'h0;
                            next_s.armed = 1'b1;
                        end
                    end
                    ACS_PH_WRITE:
                    begin
                        // Global accepts one byte, own address two
                        wrLimit = s.isGlobal ? `ACS_GLB_WR_BYTES
                                             : `ACS_OWN_WR_BYTES;
                        if (s.wrCount < wrLimit)
                        begin
                            next_s.sdaLow = 1'b1;
                            next_s.wrCount = s.wrCount + 2'h1;
                            // Held until the conversion start
                            if (s.wrCount == 2'h0)
                            begin
                                next_s.pendChan = s.shift;
                                next_s.pendChanValid = 1'b1;
                            end
                            else
                            begin
                                next_s.pendCfg = s.shift;
                                next_s.pendCfgValid = 1'b1;
                            end
                        end
                        else
                        begin
                            next_s.sdaLow = 1'b0;
                            next_s.phase = ACS_PH_IGNORE;
                        end
                    end
                    default: next_s.sdaLow = 1'b0;
                endcase
            end
            else
            begin
                if (s.bitCnt == `ACS_BIT_DONE)
                    next_s.bitCnt = 4'h0;
                // Result bits go out msb first while the clock is low
                if (s.phase == ACS_PH_READ && s.rdIdx < `ACS_RD_LIMIT)
                    next_s.sdaLow = !s.result[`ACS_IDX_LAST - s.rdIdx];
                else
                    next_s.sdaLow = 1'b0;
            end
        end

        // Conversion start applies only what was written
        if (startNow)
        begin
            next_s.armed = 1'b0;
            next_s.busy = 1'b1;
            next_s.ready = 1'b0;
            next_s.startPulse = 1'b1;
            if (s.pendChanValid)
                next_s.chan = s.pendChan;
            if (s.pendCfgValid)
                next_s.cfg = s.pendCfg;
            next_s.pendChanValid = 1'b0;
            next_s.pendCfgValid = 1'b0;
        end
    end

    // State register; a fresh device starts converting at once
    always_ff @(posedge linkClk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.sclMeta <= 1'b1;
            s.sclSamp <= 1'b1;
            s.sclPrev <= 1'b1;
            s.sdaMeta <= 1'b1;
            s.sdaSamp <= 1'b1;
            s.sdaPrev <= 1'b1;
            s.busy <= 1'b1;
            s.chan <= `ACS_CHAN_RESET;
            s.cfg <= `ACS_CFG_RESET;
        end
        else
            s <= next_s;
    end

    assign link.dSdaO = 1'b0;
    assign link.dSdaOeN = !s.sdaLow;
    assign convStart = s.startPulse;
    assign convReady = s.ready;
    assign chanSel = s.chan;
    assign convCfg = s.cfg;

endmodule : acs_device

//--- bench/acs_link_assertions.sv
`timescale 1ns/1ns
// Watches the two-wire link and the converter handshake of the device end
module acs_link_assertions (
    input wire logic mclk,
    input wire logic linkClk,
    input wire logic rst,
    input wire logic mSdaOeN,
    input wire logic dSdaOeN,
    input wire logic scl,
    input wire logic sda,
    input wire logic convStart,
    input wire logic convReady
);

    // Conversion start handshake
    a_start_one_pulse: assert property (
        @(posedge linkClk) disable iff (rst) convStart |=> !convStart)
        else $error("conversion start lasted more than one cycle");
    a_start_drops_ready: assert property (
        @(posedge linkClk) disable iff (rst)
        convStart |-> !convReady ##1 !convReady)
        else $error("ready flag still set after conversion start");
    a_ready_rise_quiet: assert property (
        @(posedge linkClk) disable iff (rst) $rose(convReady) |-> !convStart)
        else $error("ready flag rose together with a start");
    a_ready_fall_cause: assert property (
        @(posedge linkClk) disable iff (rst)
        $fell(convReady) |-> (convStart || !scl))
        else $error("ready flag dropped without start or read ack");

    // Device changes data only while the clock line is low
    a_ack_in_low: assert property (
        @(posedge linkClk) disable iff (rst) $fell(dSdaOeN) |-> !scl)
        else $error("device pulled data while clock was high");
    a_release_in_low: assert property (
        @(posedge linkClk) disable iff (rst) $rose(dSdaOeN) |-> !scl)
        else $error("device released data while clock was high");
    a_hold_high_scl: assert property (
        @(posedge linkClk) disable iff (rst)
        (!dSdaOeN && scl) |=> (!dSdaOeN || !scl))
        else $error("device data changed during clock high");

    // Start conditions come only from the master
    a_start_by_master: assert property (
        @(posedge mclk) disable iff (rst) (scl && $fell(sda)) |-> !mSdaOeN)
        else $error("start condition not made by the master");

    // Main scenarios reached
    c_conv_start: cover property (@(posedge linkClk) convStart);
    c_dev_ack: cover property (@(posedge linkClk) $fell(dSdaOeN));
    c_ready: cover property (@(posedge linkClk) $rose(convReady));

endmodule : acs_link_assertions

//--- bench/tb.sv
`timescale 1ns/1ns
`include "acs_defs.svh"
module tb;
    localparam int QTR = 8;
    logic mclk = 1'b0;
    logic linkClk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdReady;
    logic [6:0] cmdAddr = 7'h00;
    logic cmdRead = 1'b0;
    logic [1:0] cmdWrLen = 2'h0;
    logic [15:0] cmdWrData = 16'h0000;
    logic allConvDone = 1'b1;
    logic rspValid;
    logic rspAck;
    logic [23:0] rspData;
    logic [6:0] ownAddr = 7'h14;
    logic convFinish = 1'b0;
    logic [23:0] convResult = 24'h000000;
    logic convStart;
    logic convReady;
    logic [7:0] chanSel;
    logic [7:0] convCfg;
    logic [7:0] expChan = 8'h00;
    logic [7:0] expCfg = 8'h00;
    int nMismatch = 0;
    int cmpCount = 0;
    int seed = 10582;
    // Model of the results reported by the converter core, latest last
    logic [23:0] resQ[$];
    int nStart = 0;
    int expStart = 0;

    acs_link_if link ();

    acs_master #(.QTR_CYCLES(QTR)) i_acs_master (
        .mclk(mclk), .rst(rst), .link(link.master), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdRead(cmdRead),
        .cmdWrLen(cmdWrLen), .cmdWrData(cmdWrData),
        .allConvDone(allConvDone), .rspValid(rspValid), .rspAck(rspAck),
        .rspData(rspData));

    acs_device i_acs_device (
        .linkClk(linkClk), .rst(rst), .link(link.device), .ownAddr(ownAddr),
        .convFinish(convFinish), .convResult(convResult),
        .convStart(convStart), .convReady(convReady), .chanSel(chanSel),
        .convCfg(convCfg));

    acs_link_assertions i_acs_link_assertions (
        .mclk(mclk), .linkClk(linkClk), .rst(rst), .mSdaOeN(link.mSdaOeN),
        .dSdaOeN(link.dSdaOeN), .scl(link.scl), .sda(link.sda),
        .convStart(convStart), .convReady(convReady));

    // Master clock and an unrelated link clock
    always #10 mclk = ~mclk;
    initial
    begin
        #3;
        forever #6 linkClk = ~linkClk;
    end

    // Counts conversion starts of the device
    always @(posedge linkClk)
        if (convStart === 1'b1)
            nStart <= nStart + 1;

    task fail(input string msg);
        nMismatch++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail

    task conclude;
        if (nMismatch == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    // Compares the master's response
    task check_rsp(input logic ack, input logic withData,
                   input logic [23:0] data);
        cmpCount++;
        if (rspAck !== ack || (withData && rspData !== data))
            fail("response ack or data");
    endtask : check_rsp

    // Compares the master's command readiness
    task check_ready(input logic exp);
        cmpCount++;
        if (cmdReady !== exp)
            fail("command ready");
    endtask : check_ready

    // Compares the device state with the model
    task check_dev(input logic ready);
        cmpCount++;
        if (chanSel !== expChan || convCfg !== expCfg ||
            convReady !== ready || nStart != expStart)
            fail("device channel, config, ready or start count");
    endtask : check_dev

    // One command through the master, waiting for its response
    task xfer(input logic [6:0] a, input logic rd, input logic [1:0] n,
              input logic [15:0] d);
        int i;
        @(negedge mclk);
        cmdAddr = a;
        cmdRead = rd;
        cmdWrLen = n;
        cmdWrData = d;
        cmdValid = 1'b1;
        for (i = 0; i < 100 && cmdReady !== 1'b1; i++)
            @(negedge mclk);
        @(negedge mclk);
        cmdValid = 1'b0;
        for (i = 0; i < 4000 && rspValid !== 1'b1; i++)
            @(negedge mclk);
        if (i == 4000)
            fail("no response");
        repeat (20) @(negedge mclk);
    endtask : xfer

    // Converter core reports a finished result
    task finish_conv(input logic [23:0] r);
        @(negedge linkClk);
        convFinish = 1'b1;
        convResult = r;
        resQ.push_back(r);
        @(negedge linkClk);
        convFinish = 1'b0;
        repeat (3) @(negedge linkClk);
    endtask : finish_conv

    // Acked write, then model update at its Stop
    task write_ok(input logic [6:0] a, input logic [1:0] n,
                  input logic [15:0] d);
        xfer(a, 1'b0, n, d);
        check_rsp(1'b1, 1'b0, 24'h000000);
        if (n != 2'h0)
            expChan = d[15:8];
        if (n == 2'h2)
            expCfg = d[7:0];
        expStart++;
        check_dev(1'b0);
    endtask : write_ok

    // Main sequence
    initial
    begin
        logic [23:0] r;
        logic [15:0] d;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        repeat (10) @(negedge mclk);
        check_dev(1'b0);
        xfer(ownAddr, 1'b1, 2'h0, 16'h0000);
        check_rsp(1'b0, 1'b0, 24'h000000);
        r = 24'($random(seed));
        finish_conv(r);
        check_dev(1'b1);
        xfer(ownAddr, 1'b1, 2'h0, 16'h0000);
        check_rsp(1'b1, 1'b1, resQ[$]);
        expStart++;
        check_dev(1'b0);
        for (int k = 0; k < 6; k++)
        begin
            finish_conv(24'($random(seed)));
            d = 16'($random(seed));
            write_ok(ownAddr, 2'(k % 3), d);
        end
        // Foreign address is ignored
        finish_conv(24'h000000);
        xfer(ownAddr ^ 7'h01, 1'b0, 2'h0, 16'h0000);
        check_rsp(1'b0, 1'b0, 24'h000000);
        check_dev(1'b1);
        // Global command held back until all conversions are done
        @(negedge mclk);
        allConvDone = 1'b0;
        cmdAddr = `ACS_GLOBAL_ADDR;
        @(negedge mclk);
        check_ready(1'b0);
        allConvDone = 1'b1;
        @(negedge mclk);
        check_ready(1'b1);
        for (int k = 0; k < 4; k++)
        begin
            d = 16'($random(seed));
            write_ok(`ACS_GLOBAL_ADDR, 2'(k % 2), d);
            finish_conv(24'h000000);
        end
        write_ok(`ACS_GLOBAL_ADDR, 2'h0, 16'h0000);
        // Busy device refuses the global address too
        xfer(`ACS_GLOBAL_ADDR, 1'b0, 2'h1, 16'h5a00);
        check_rsp(1'b0, 1'b0, 24'h000000);
        check_dev(1'b0);
        finish_conv(24'h000000);
        xfer(`ACS_GLOBAL_ADDR, 1'b1, 2'h0, 16'h0000);
        check_rsp(1'b0, 1'b1, 24'h000000);
        check_dev(1'b1);
        conclude();
    end

    // Watchdog against a hang
    initial
    begin
        #(60000 * 20);
        fail("watchdog expired");
        conclude();
    end

endmodule : tb
